// ### tss_consumer.sv
// Purpose: downstream logic that consumes the schedule output
// Assumes: switch_out is a registered level
// Notes:   counts rising edges so glitches or missed events show up
`timescale 1ns/1ps
module tss_consumer
  import tss_pkg::*;
(
  input  wire logic  mclk,
  input  wire logic  nrst,
  input  wire logic  switch_out,
  output logic [7:0] rise_cnt
);
  logic last_q;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      last_q   <= 1'b0;
      rise_cnt <= 8'h0;
    end
    else
    begin
      last_q <= switch_out;
      if (switch_out && !last_q)
        rise_cnt <= rise_cnt + 8'h1;
    end
  end
endmodule : tss_consumer

// ### tss_pkg.sv
// Purpose: constants and types shared by the time schedule switch block
// Assumes: 25 MHz mclk, APB register access, one schedule output channel
// Notes:   times of day are held as a count of seconds since midnight
package tss_pkg;

  localparam int unsigned CLK_HZ       = 25_000_000;
  localparam int unsigned TICK_S       = 1;
  localparam int unsigned TICK_CYCLES  = CLK_HZ * TICK_S;
  localparam int unsigned TICK_W       = 25;

  localparam int unsigned ENTRY_MAX    = 127;
  localparam int unsigned IDX_W        = 7;
  localparam int unsigned SEC_W        = 17;
  localparam int unsigned DAY_W        = 16;
  localparam int unsigned SEL_W        = 4;

  localparam logic [SEC_W-1:0] SEC_LAST = 17'h1517f;   // 23:59:59
  localparam logic [SEC_W-1:0] NOT_SET  = 17'h15180;   // 24:00:00
  localparam logic [2:0]       WDAY_MON = 3'h0;
  localparam logic [2:0]       WDAY_SUN = 3'h6;

  // weekday selection codes: 0..6 single days Monday..Sunday, then ranges
  localparam logic [SEL_W-1:0] SEL_MO_SU = 4'h7;
  localparam logic [SEL_W-1:0] SEL_MO_TH = 4'h8;
  localparam logic [SEL_W-1:0] SEL_MO_FR = 4'h9;
  localparam logic [SEL_W-1:0] SEL_MO_SA = 4'ha;
  localparam logic [SEL_W-1:0] SEL_FR_SU = 4'hb;
  localparam logic [SEL_W-1:0] SEL_SA_SU = 4'hc;
  localparam logic [2:0]       WDAY_THU  = 3'h3;
  localparam logic [2:0]       WDAY_FRI  = 3'h4;
  localparam logic [2:0]       WDAY_SAT  = 3'h5;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TIME   = 8'h08;
  localparam logic [7:0] ADDR_DATE   = 8'h0c;
  localparam logic [7:0] ADDR_INDEX  = 8'h10;
  localparam logic [7:0] ADDR_ON     = 8'h14;
  localparam logic [7:0] ADDR_OFF    = 8'h18;
  localparam logic [7:0] ADDR_SEL    = 8'h1c;

  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_WEEK_BIT = 1;
  localparam int unsigned CTRL_CNT_LSB  = 8;
  localparam int unsigned TIME_WDAY_LSB = 20;
  localparam int unsigned SEL_CODE_LSB  = 16;
  localparam int unsigned STAT_Q_BIT    = 0;
  localparam int unsigned STAT_BUSY_BIT = 1;

  typedef struct packed {
    logic [SEC_W-1:0] secs;
    logic [2:0]       wday;
    logic [DAY_W-1:0] day;
  } tss_time_s;

endpackage : tss_pkg

// ### tss_rtc.sv
// Purpose: time of day, weekday and day counter advanced once a second
// Assumes: tick is a one-cycle pulse once per second
// Notes:   in silicon this sits on the backup supply; here its reset is the shared nrst of the block
`timescale 1ns/1ps
module tss_rtc
  import tss_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               nrst,
  input  wire logic               tick,
  input  wire logic               load_time,
  input  wire logic [SEC_W-1:0]   load_secs,
  input  wire logic [2:0]         load_wday,
  input  wire logic               load_day,
  input  wire logic [DAY_W-1:0]   load_day_val,
  output tss_pkg::tss_time_s      now
);
  tss_time_s st;
  tss_time_s next_st;

  always_comb
  begin
    next_st = st;
    if (tick)   // keeps running with the clock, independent of the schedule enable
    begin
      if (st.secs == SEC_LAST)
      begin
        next_st.secs = '0;
        next_st.day  = st.day + DAY_W'(1);
        next_st.wday = (st.wday == WDAY_SUN) ? WDAY_MON : st.wday + 3'h1;
      end
      else
      begin
        next_st.secs = st.secs + SEC_W'(1);
      end
    end
    // software writes take priority over the tick in the same cycle
    if (load_time)
    begin
      next_st.secs = load_secs;
      next_st.wday = load_wday;
    end
    if (load_day)
      next_st.day = load_day_val;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      st <= '0;
    else
      st <= next_st;
  end

  assign now = st;

endmodule : tss_rtc

// ### tss_switch.sv
// Purpose: clock schedule switch with APB registers and one switched output
// Assumes: APB master per the usual protocol, single mclk domain
// Notes:   the schedule is scanned once per second, entry 0 first, in index order
`timescale 1ns/1ps
module tss_switch
  import tss_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = tss_pkg::TICK_CYCLES
)
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             switch_out
);
  typedef struct packed {
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             en;
    logic             week_mode;
    logic [IDX_W-1:0] count;
    logic [IDX_W-1:0] index;
    logic             busy;
    logic [IDX_W-1:0] scan_idx;
    logic             pend;
    logic             q;
  } tss_sw_s;

  tss_sw_s   st;
  tss_sw_s   next_st;
  tss_time_s now;
  logic      tick;

  // entry storage; not reset, only the first count entries are scanned
  logic [SEC_W-1:0]       on_mem  [0:ENTRY_MAX-1];
  logic [SEC_W-1:0]       off_mem [0:ENTRY_MAX-1];
  logic [DAY_W+SEL_W-1:0] sel_mem [0:ENTRY_MAX-1];

  logic                   acc;
  logic                   wr;
  logic                   mem_idx_ok;
  logic                   load_time;
  logic                   load_day;
  logic [SEC_W-1:0]       cur_on;
  logic [SEC_W-1:0]       cur_off;
  logic [DAY_W+SEL_W-1:0] cur_sel;
  logic                   day_ok;
  logic                   on_hit;
  logic                   off_hit;

  tss_tick #(
    .CYCLES (TICK_CYCLES)
  ) u_tick (
    .mclk (mclk),
    .nrst (nrst),
    .tick (tick)
  );

  tss_rtc u_rtc (
    .mclk         (mclk),
    .nrst         (nrst),
    .tick         (tick),
    .load_time    (load_time),
    .load_secs    (pwdata[SEC_W-1:0]),
    .load_wday    (pwdata[TIME_WDAY_LSB+2:TIME_WDAY_LSB]),
    .load_day     (load_day),
    .load_day_val (pwdata[DAY_W-1:0]),
    .now          (now)
  );

  // weekday selection against today, Monday = 0 .. Sunday = 6
  function automatic logic wday_match(input logic [SEL_W-1:0] code, input logic [2:0] wday);
    logic hit;
    hit = 1'b0;
    if (code == SEL_MO_SU)
      hit = 1'b1;
    else if (code == SEL_MO_TH)
      hit = (wday <= WDAY_THU);
    else if (code == SEL_MO_FR)
      hit = (wday <= WDAY_FRI);
    else if (code == SEL_MO_SA)
      hit = (wday <= WDAY_SAT);
    else if (code == SEL_FR_SU)
      hit = (wday >= WDAY_FRI);
    else if (code == SEL_SA_SU)
      hit = (wday >= WDAY_SAT);
    else if (code <= {1'b0, WDAY_SUN})
      hit = (code[2:0] == wday);
    return hit;   // ranges never wrap past Sunday
  endfunction : wday_match

  // access phase with pready high is the one edge where a transfer completes
  assign acc        = psel && penable && st.pready;
  assign wr         = acc && pwrite;
  assign mem_idx_ok = (st.index < IDX_W'(ENTRY_MAX));
  assign load_time  = wr && (paddr == ADDR_TIME) && (pwdata[SEC_W-1:0] <= SEC_LAST)
                      && (pwdata[TIME_WDAY_LSB+2:TIME_WDAY_LSB] <= WDAY_SUN);
  assign load_day   = wr && (paddr == ADDR_DATE);

  assign cur_on  = on_mem[st.scan_idx];
  assign cur_off = off_mem[st.scan_idx];
  assign cur_sel = sel_mem[st.scan_idx];

  always_comb
  begin
    if (st.week_mode)
      day_ok = wday_match(cur_sel[SEL_CODE_LSB+SEL_W-1:SEL_CODE_LSB],
                          now.wday);
    else
      day_ok = (cur_sel[DAY_W-1:0] == now.day);
  end

  // a setting of 24:00:00 or above never matches the clock, so no event comes from it
  assign on_hit  = day_ok && (cur_on != NOT_SET) && (cur_on == now.secs);
  assign off_hit = day_ok && (cur_off != NOT_SET) && (cur_off == now.secs);

  always_ff @(posedge mclk)
  begin
    if (wr && mem_idx_ok && (paddr == ADDR_ON))
      on_mem[st.index] <= pwdata[SEC_W-1:0];
    if (wr && mem_idx_ok && (paddr == ADDR_OFF))
      off_mem[st.index] <= pwdata[SEC_W-1:0];
    if (wr && mem_idx_ok && (paddr == ADDR_SEL))
      sel_mem[st.index] <= pwdata[DAY_W+SEL_W-1:0];
  end

  always_comb
  begin
    next_st = st;

    // APB: one wait-free access phase, answer registered at the setup edge
    next_st.pready  = psel && !penable && !st.pready;
    next_st.pslverr = 1'b0;
    if (psel && !penable)
    begin
      next_st.prdata = '0;
      if (paddr == ADDR_CTRL)
      begin
        next_st.prdata[CTRL_EN_BIT]                       = st.en;
        next_st.prdata[CTRL_WEEK_BIT]                     = st.week_mode;
        next_st.prdata[CTRL_CNT_LSB+IDX_W-1:CTRL_CNT_LSB] = st.count;
      end
      else if (paddr == ADDR_STATUS)
      begin
        next_st.prdata[STAT_Q_BIT]    = st.q;
        next_st.prdata[STAT_BUSY_BIT] = st.busy;
      end
      else if (paddr == ADDR_TIME)
      begin
        next_st.prdata[SEC_W-1:0]                    = now.secs;
        next_st.prdata[TIME_WDAY_LSB+2:TIME_WDAY_LSB] = now.wday;
      end
      else if (paddr == ADDR_DATE)
      begin
        next_st.prdata[DAY_W-1:0] = now.day;
      end
      else if (paddr == ADDR_INDEX)
      begin
        next_st.prdata[IDX_W-1:0] = st.index;
      end
      else if (paddr == ADDR_ON)
      begin
        if (mem_idx_ok)
          next_st.prdata[SEC_W-1:0] = on_mem[st.index];
      end
      else if (paddr == ADDR_OFF)
      begin
        if (mem_idx_ok)
          next_st.prdata[SEC_W-1:0] = off_mem[st.index];
      end
      else if (paddr == ADDR_SEL)
      begin
        if (mem_idx_ok)
          next_st.prdata[DAY_W+SEL_W-1:0] = sel_mem[st.index];
      end
      else
      begin
        next_st.pslverr = 1'b1;
      end
    end

    if (wr)
    begin
      if (paddr == ADDR_CTRL)
      begin
        next_st.en        = pwdata[CTRL_EN_BIT];
        next_st.week_mode = pwdata[CTRL_WEEK_BIT];
        next_st.count     = pwdata[CTRL_CNT_LSB+IDX_W-1:CTRL_CNT_LSB];
      end
      else if (paddr == ADDR_INDEX)
      begin
        next_st.index = pwdata[IDX_W-1:0];
      end
    end

    // once a second walk the list in order; each hit overrides what came before
    if (!st.busy)
    begin
      if (tick && st.en && (st.count != '0))
      begin
        next_st.busy     = 1'b1;
        next_st.scan_idx = '0;
        next_st.pend     = st.q;   // no event keeps the former state
      end
    end
    else
    begin
      if (on_hit)
        next_st.pend = 1'b1;
      if (off_hit)
        next_st.pend = 1'b0;
      // a count rewritten mid-scan must not let the walk run on past the last entry
      if (({1'b0, st.scan_idx} + 8'h01) >= {1'b0, st.count})
      begin
        next_st.busy = 1'b0;
        // only the net result is driven out, so an on and off in the same
        // second never shows a glitch on the output
        if (on_hit)
          next_st.q = 1'b1;
        else if (off_hit)
          next_st.q = 1'b0;
        else
          next_st.q = st.pend;
        if (on_hit && off_hit)
          next_st.q = 1'b0;
      end
      else
      begin
        next_st.scan_idx = st.scan_idx + IDX_W'(1);
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      st <= '0;
    else
      st <= next_st;
  end

  assign prdata     = st.prdata;
  assign pready     = st.pready;
  assign pslverr    = st.pslverr;
  assign switch_out = st.q;

endmodule : tss_switch

// ### tss_switch_checker.sv
// Purpose: port assertions for the schedule switch
// Assumes: bound to every tss_switch instance
// Notes:   tick timing is not visible here, so output spacing stands in for it
`timescale 1ns/1ps
module tss_switch_checker
  import tss_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 8
)
(
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        switch_out
);
  logic [31:0] since;
  logic        last_out;
  // saturates so a long quiet spell cannot wrap into a false short gap
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      since    <= 32'h0;
      last_out <= 1'b0;
    end
    else
    begin
      last_out <= switch_out;
      // wide enough for a full second at the real clock rate
      if (switch_out != last_out)
        since <= 32'h1;
      else if (since != 32'hffffffff)
        since <= since + 32'h1;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_setup; psel && !penable; endsequence
  sequence s_access; psel && penable; endsequence
  a_rdy_after_setup: assert property (s_setup ##1 s_access |-> pready)
    else $error("pready missing in access phase");
  a_rdy_one_cycle: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_rdy_in_access: assert property (pready |-> s_access)
    else $error("pready outside access phase");
  a_err_unmapped: assert property (s_setup and (paddr > ADDR_SEL) |=> pslverr)
    else $error("no error for unmapped address");
  a_no_err_mapped: assert property ((psel && !penable && paddr <= ADDR_SEL && paddr[1:0] == 2'h0)
    |=> !pslverr) else $error("error on mapped address");
  a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response with data");
  a_rdata_holds: assert property ((!psel || penable) |=> $stable(prdata))
    else $error("read data moved outside setup");
  sequence s_time_rd; s_access && !pwrite && (paddr == ADDR_TIME); endsequence
  a_time_in_range: assert property (s_setup ##1 s_time_rd |->
    (prdata[SEC_W-1:0] <= SEC_LAST) && (prdata[TIME_WDAY_LSB+2:TIME_WDAY_LSB] <= WDAY_SUN))
    else $error("time read out of range");
  a_out_spacing: assert property ($changed(switch_out) |-> since >= TICK_CYCLES - 1)
    else $error("output changed twice within one second");
endmodule : tss_switch_checker

bind tss_switch tss_switch_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.mclk(mclk), .nrst(nrst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .switch_out(switch_out));

// ### tss_switch_tb.sv
// Purpose: self-checking bench for the schedule switch
// Assumes: one second shortened to 8 mclk cycles
// Notes:   reads are queued as expectations and judged by a bus monitor
`timescale 1ns/1ps
module tss_switch_tb;
  import tss_pkg::*;
  logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, switch_out;
  logic [7:0]  paddr, rise_cnt, exp_rises;
  logic [31:0] pwdata, prdata;
  logic [16:0] on_s;
  logic [64:0] q[$];
  logic [64:0] e;
  integer      seed, err_count, checks;

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  tss_switch #(.TICK_CYCLES(8)) DUT (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .switch_out(switch_out));
  tss_consumer u_cons (.mclk(mclk), .nrst(nrst), .switch_out(switch_out), .rise_cnt(rise_cnt));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    // no local limit: only the watchdog may end a wait for pready
    while (pready !== 1'b1)
      @(posedge mclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m,
                    input logic er);
    q.push_back({er, m, x & m});
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic wait_out(input logic v);
    int n;
    n = 0;
    while (switch_out !== v && n < 100)
    begin
      @(posedge mclk);
      n = n + 1;
    end
    check({31'h0, switch_out}, {31'h0, v});
  endtask : wait_out

  // entry 0 forces the output off, the later entry 1 may turn it on again
  task automatic run_case(input logic [31:0] sel, input logic wk, input logic [16:0] off0,
                          input logic ex);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_INDEX, 32'h0);
    wr(ADDR_ON, {15'h0, NOT_SET});
    wr(ADDR_OFF, {15'h0, off0});
    wr(ADDR_SEL, 32'h70005);
    wr(ADDR_INDEX, 32'h1);
    wr(ADDR_ON, 32'h12e);
    wr(ADDR_OFF, {15'h0, NOT_SET});
    wr(ADDR_SEL, sel);
    wr(ADDR_CTRL, {30'h80, wk, 1'b1});
    wr(ADDR_TIME, 32'h12c);
    repeat (30) @(posedge mclk);
    rd(ADDR_STATUS, {31'h0, ex}, 32'h1, 1'b0);
    exp_rises = exp_rises + {7'h0, ex};
    $display("test case sel %h done", sel);
  endtask : run_case

  always @(posedge mclk)
  begin
    if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0)
    begin
      e = q.pop_front();
      check(prdata & e[63:32], e[31:0]);
      check({31'h0, pslverr}, {31'h0, e[64]});
    end
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    err_count = err_count + 1;
    report_and_stop;
  end

  initial
  begin
    seed      = 27;
    err_count = 0;
    checks    = 0;
    exp_rises = 8'h1;
    nrst      = 1'b0;
    psel      = 1'b0;
    penable   = 1'b0;
    pwrite    = 1'b0;
    paddr     = 8'h0;
    pwdata    = 32'h0;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    rd(ADDR_CTRL, 32'h0, 32'hffffffff, 1'b0);
    rd(8'h20, 32'h0, 32'hffffffff, 1'b1);
    wr(ADDR_INDEX, 32'h7e);
    wr(ADDR_ON, 32'h5);
    rd(ADDR_ON, 32'h5, 32'h1ffff, 1'b0);
    wr(ADDR_INDEX, 32'h7f);
    wr(ADDR_ON, 32'h5);
    rd(ADDR_ON, 32'h0, 32'hffffffff, 1'b0);
    $display("test registers done");
    on_s = 17'h3e8 + 17'($random(seed) & 7);
    wr(ADDR_INDEX, 32'h0);
    wr(ADDR_ON, {15'h0, on_s});
    wr(ADDR_OFF, {15'h0, on_s + 17'h3});
    wr(ADDR_SEL, 32'h70000);
    wr(ADDR_INDEX, 32'h1);
    wr(ADDR_ON, {15'h0, NOT_SET});
    wr(ADDR_OFF, {15'h0, NOT_SET});
    wr(ADDR_SEL, 32'h70000);
    wr(ADDR_CTRL, 32'h203);
    wr(ADDR_TIME, {15'h0, on_s - 17'h2});
    wait_out(1'b1);
    rd(ADDR_TIME, {15'h0, on_s}, 32'h1ffff, 1'b0);
    wait_out(1'b0);
    rd(ADDR_TIME, {15'h0, on_s + 17'h3}, 32'h1ffff, 1'b0);
    $display("test interval done");
    wr(ADDR_DATE, 32'h5);
    for (int i = 0; i < 16; i++)
      run_case({12'h0, 4'(i), 16'h9}, 1'b1, 17'h12d,
               i == 0 || (i >= 7 && i <= 10));
    run_case(32'h70005, 1'b0, 17'h12d, 1'b1);
    run_case(32'h70006, 1'b0, 17'h12d, 1'b0);
    run_case(32'h70009, 1'b1, 17'h12e, 1'b1);
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_TIME, {9'h0, 3'h6, 3'h0, SEC_LAST});
    repeat (12) @(posedge mclk);
    rd(ADDR_TIME, 32'h0, 32'h00700000, 1'b0);
    rd(ADDR_DATE, 32'h6, 32'hffff, 1'b0);
    $display("test rollover done");
    repeat (2) @(posedge mclk);
    check({24'h0, rise_cnt}, {24'h0, exp_rises});
    report_and_stop;
  end
endmodule : tss_switch_tb

// ### tss_tick.sv
// Purpose: one-second enable pulse from the master clock
// Assumes: cycles parameter is the number of mclk cycles per second
// Notes:   shorten cycles in simulation only
`timescale 1ns/1ps
module tss_tick
  import tss_pkg::*;
#(
  parameter int unsigned CYCLES = tss_pkg::TICK_CYCLES
)
(
  input  wire logic mclk,
  input  wire logic nrst,
  output logic      tick
);
  typedef struct packed {
    logic [TICK_W-1:0] cnt;
    logic              tick;
  } tss_tick_s;

  localparam logic [TICK_W-1:0] LAST = TICK_W'(CYCLES - 1);

  tss_tick_s st;
  tss_tick_s next_st;

  always_comb
  begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.cnt == LAST)
    begin
      next_st.cnt  = '0;
      next_st.tick = 1'b1;
    end
    else
    begin
      next_st.cnt = st.cnt + TICK_W'(1);
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      st <= '0;
    else
      st <= next_st;
  end

  assign tick = st.tick;

endmodule : tss_tick
